// ===== hw/sbx_pkg.sv
// Package: opcodes, load selects, reset values and states of the stack/branch unit
package sbx_pkg;
	// ==========================================================
	// Fixed opcodes and opcode patterns
	localparam logic [7:0] OP_EXIT = 8'hc9;
	localparam logic [7:0] OP_CALL = 8'hcd;
	localparam logic [7:0] OP_JMP_PAIR = 8'he9;
	localparam logic [7:0] OP_SWAP_TOP = 8'he3;
	localparam logic [7:0] OP_LD_STACK = 8'hf9;
	localparam logic [7:0] OP_IN = 8'hdb;
	localparam logic [7:0] OP_OUT = 8'hd3;
	localparam logic [7:0] OP_IRQ_EN = 8'hfb;
	localparam logic [7:0] OP_IRQ_MASK = 8'hf3;
	localparam logic [7:0] OP_HALT = 8'h76;
	localparam logic [7:0] OP_IDLE = 8'h00;
	localparam logic [7:0] OP_MUL_DEF = 8'hee;
	localparam logic [7:0] OP_DIV_DEF = 8'hfe;
	// Low three or four bits select the family of 11xxxyyy opcodes
	localparam logic [2:0] LOW_CRET = 3'h0;
	localparam logic [2:0] LOW_CCALL = 3'h4;
	localparam logic [2:0] LOW_RESTART = 3'h7;
	localparam logic [3:0] LOW_PUSH = 4'h5;
	localparam logic [3:0] LOW_POP = 4'h1;
	localparam logic [1:0] PAIR_PSW = 2'h3;
	// ==========================================================
	// Status byte layout
	localparam int FB_SIGN = 7;
	localparam int FB_ZERO = 6;
	localparam int FB_HALF = 4;
	localparam int FB_PAR = 2;
	localparam int FB_CARRY = 0;
	localparam logic [7:0] FB_FIXED = 8'h02;
	// ==========================================================
	// Load port selects and reset values
	localparam logic [3:0] SEL_A = 4'h0;
	localparam logic [3:0] SEL_B = 4'h1;
	localparam logic [3:0] SEL_C = 4'h2;
	localparam logic [3:0] SEL_D = 4'h3;
	localparam logic [3:0] SEL_E = 4'h4;
	localparam logic [3:0] SEL_H = 4'h5;
	localparam logic [3:0] SEL_L = 4'h6;
	localparam logic [3:0] SEL_FLAGS = 4'h7;
	localparam logic [3:0] SEL_SP = 4'h8;
	localparam logic [3:0] SEL_PC = 4'h9;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] STEP_TWO = 16'h0002;
	localparam logic [15:0] STEP_ONE = 16'h0001;
	// ==========================================================
	// Sequencer states, Gray from ST_POP_LO through ST_SWAP_HI
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_PUSH_LO = 4'h1,
		ST_POP_LO = 4'h3,
		ST_POP_HI = 4'h2,
		ST_POP_END = 4'h6,
		ST_SWAP_HI = 4'h7,
		ST_IO_WAIT = 4'h5,
		ST_IO_CAP = 4'h4,
		ST_MULDIV = 4'hc,
		ST_DONE = 4'hd
	} sbx_state_e;
endpackage : sbx_pkg

// ===== hw/sbx_md_if.sv
// Interface: handshake between sequencer and multiply/divide unit
`timescale 1ns/10ps
`default_nettype none
interface sbx_md_if;
	logic start;
	logic is_div;
	logic [7:0] acc;
	logic [7:0] breg;
	logic [7:0] creg;
	logic done;
	logic [7:0] res_hi;
	logic [7:0] res_lo;
	modport seq (output start, is_div, acc, breg, creg,
		input done, res_hi, res_lo);
	modport unit (input start, is_div, acc, breg, creg,
		output done, res_hi, res_lo);
endinterface : sbx_md_if
`default_nettype wire

// ===== hw/sbx_muldiv.sv
// Multiply/divide unit: one-cycle registered result
`timescale 1ns/10ps
`default_nettype none
module sbx_muldiv (
	input wire logic clk,
	input wire logic rst,
	sbx_md_if.unit md
);
	logic [15:0] prod;
	logic [7:0] quot;
	logic [7:0] rem;
	logic div_zero;
	// ==========================================================
	// Arithmetic; a zero divisor gives all-ones and keeps dividend
	assign prod = {8'h00, md.acc} * {8'h00, md.breg};
	assign div_zero = (md.acc == 8'h00);
	assign quot = div_zero ? 8'hff : md.creg / md.acc;
	assign rem = div_zero ? md.creg : md.creg % md.acc;
	// Result: high byte is product high or remainder
	always_ff @(posedge clk) begin
		if (rst) begin
			md.done <= 1'b0;
			md.res_hi <= 8'h00;
			md.res_lo <= 8'h00;
		end else begin
			md.done <= md.start;
			if (md.start) begin
				md.res_hi <= md.is_div ? rem : prod[15:8];
				md.res_lo <= md.is_div ? quot : prod[7:0];
			end
		end
	end
endmodule : sbx_muldiv
`default_nettype wire

// ===== hw/sbx_exec.sv
// Stack, branch, port and machine-control execution unit
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Condition field 000..111: nz, z, nc, c, po, pe, p, m.
// - Taken conditional call pushes return high then low, sp-2, jumps.
// - Return loads pc low from (sp), high from (sp+1), sp+2.
// - Conditional return acts only when condition holds.
// - Restart pushes like a call and jumps to eight times vector.
// - Jump via pair copies H and L into pc.
// - Push writes high at sp-1, low at sp-2, then sp-2.
// - Status push: accumulator at sp-1, flag byte S Z 0 AC 0 P 1 CY.
// - Pop loads low from (sp), high from (sp+1), sp+2.
// - Status pop restores flags from bits 0,2,4,6,7, then A, sp+2.
// - Stack-top swap exchanges L with (sp), H with (sp+1).
// - Load stack from pair copies H:L into sp.
// - Port input captures port byte into accumulator.
// - Port output drives accumulator onto the data bus.
// - Interrupt enable takes effect after the following instruction.
// - Interrupt mask disables interrupts at once.
// - Halt stops execution, all registers and flags kept.
// - Idle changes no register or flag.
// - Multiply A by B into B:C, carry gets product top bit.
// - Divide C by A: quotient to C, remainder B, carry lsb, ac 1.
// - These instructions leave flags alone unless stated.
module sbx_exec #(
	parameter logic [7:0] OP_MUL = sbx_pkg::OP_MUL_DEF,
	parameter logic [7:0] OP_DIV = sbx_pkg::OP_DIV_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] imm_lo,
	input wire logic [7:0] imm_hi,
	input wire logic [15:0] next_pc,
	input wire logic ld_en,
	input wire logic [3:0] ld_sel,
	input wire logic [15:0] ld_data,
	input wire logic [7:0] mem_rdata,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_wr,
	output logic mem_rd,
	output logic [7:0] io_port,
	output logic io_rd,
	output logic io_wr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic busy,
	output logic done,
	output logic halted,
	output logic irq_enabled,
	output logic [7:0] acc,
	output logic [7:0] reg_b,
	output logic [7:0] reg_c,
	output logic [7:0] reg_d,
	output logic [7:0] reg_e,
	output logic [7:0] reg_h,
	output logic [7:0] reg_l,
	output logic sign_flag,
	output logic zero_flag,
	output logic half_carry_flag,
	output logic parity_flag,
	output logic carry_flag,
	output logic [15:0] stack_pointer,
	output logic [15:0] program_counter
);
	sbx_pkg::sbx_state_e state_reg;
	logic [7:0] a_reg, b_reg, c_reg, d_reg, e_reg, h_reg, l_reg;
	logic s_reg, z_reg, ac_reg, p_reg, cy_reg;
	logic [15:0] sp_reg, pc_reg, tgt_reg, mem_addr_reg;
	logic [7:0] op_reg, tmp_lo_reg, wdata_reg, port_reg, dout_reg;
	logic mem_wr_reg, mem_rd_reg, io_rd_reg, io_wr_reg, oe_reg;
	logic busy_reg, done_reg, halt_reg, inte_reg, ei_pend_reg, md_start_reg;
	logic [15:0] seq_pc_reg;
	sbx_md_if md ();

	// ==========================================================
	// Decode of the accepted opcode
	wire accept = start && !busy_reg && !halt_reg;
	wire [2:0] ccc = opcode[5:3];
	wire [7:0] cond_vec = {s_reg, !s_reg, p_reg, !p_reg,
		cy_reg, !cy_reg, z_reg, !z_reg};
	wire cond_ok = cond_vec[ccc];
	wire top2 = (opcode[7:6] == 2'b11);
	wire is_ccall = top2 && (opcode[2:0] == sbx_pkg::LOW_CCALL);
	wire is_cret = top2 && (opcode[2:0] == sbx_pkg::LOW_CRET);
	wire is_rst = top2 && (opcode[2:0] == sbx_pkg::LOW_RESTART);
	wire is_push = top2 && (opcode[3:0] == sbx_pkg::LOW_PUSH);
	wire is_pop = top2 && (opcode[3:0] == sbx_pkg::LOW_POP);
	wire take_call = (is_ccall && cond_ok) || opcode == sbx_pkg::OP_CALL;
	wire take_ret = (is_cret && cond_ok) || opcode == sbx_pkg::OP_EXIT;
	wire is_md = (opcode == OP_MUL) || (opcode == OP_DIV);
	wire [15:0] rst_vec = {10'h000, ccc, 3'b000};
	// Status byte with the fixed bits forced
	wire [7:0] flag_byte = {s_reg, z_reg, 1'b0, ac_reg, 1'b0, p_reg,
		1'b1, cy_reg};
	// Pair chosen by bits 5:4; pair 3 is A with the status byte
	wire [1:0] rp = opcode[5:4];
	wire [7:0] pair_hi = (rp == 2'h0) ? b_reg : (rp == 2'h1) ? d_reg :
		(rp == 2'h2) ? h_reg : a_reg;
	wire [7:0] pair_lo = (rp == 2'h0) ? c_reg : (rp == 2'h1) ? e_reg :
		(rp == 2'h2) ? l_reg : flag_byte;
	wire op_pop = op_reg[7:6] == 2'b11 && op_reg[3:0] == sbx_pkg::LOW_POP;
	wire op_swap = op_reg == sbx_pkg::OP_SWAP_TOP;
	// 16-bit sums drop the carry so addresses wrap
	wire [15:0] sp_m1 = sp_reg - sbx_pkg::STEP_ONE;
	wire [15:0] sp_m2 = sp_reg - sbx_pkg::STEP_TWO;
	wire [15:0] sp_p1 = sp_reg + sbx_pkg::STEP_ONE;
	wire [15:0] sp_p2 = sp_reg + sbx_pkg::STEP_TWO;

	assign md.start = md_start_reg;
	assign md.is_div = (op_reg == OP_DIV);
	assign md.acc = a_reg;
	assign md.breg = b_reg;
	assign md.creg = c_reg;
	sbx_muldiv u_md (.clk(clk), .rst(rst), .md(md.unit));

	// ==========================================================
	// Sequencer; flags change only in pop-status, multiply, divide and flag loads
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= sbx_pkg::ST_IDLE;
			{a_reg, b_reg, c_reg, d_reg} <= {4{sbx_pkg::RST_BYTE}};
			{e_reg, h_reg, l_reg, op_reg} <= {4{sbx_pkg::RST_BYTE}};
			{tmp_lo_reg, wdata_reg} <= {2{sbx_pkg::RST_BYTE}};
			{port_reg, dout_reg} <= {2{sbx_pkg::RST_BYTE}};
			{s_reg, z_reg, ac_reg, p_reg, cy_reg} <= 5'h00;
			{sp_reg, pc_reg} <= {2{sbx_pkg::RST_WORD}};
			{tgt_reg, mem_addr_reg} <= {2{sbx_pkg::RST_WORD}};
			{mem_wr_reg, mem_rd_reg, io_rd_reg, io_wr_reg} <= 4'h0;
			{oe_reg, busy_reg, done_reg, halt_reg} <= 4'h0;
			{inte_reg, ei_pend_reg, md_start_reg} <= 3'h0;
		end else begin
			{mem_wr_reg, mem_rd_reg, io_rd_reg, io_wr_reg} <= 4'h0;
			{oe_reg, done_reg, md_start_reg} <= 3'h0;
			case (state_reg)
				sbx_pkg::ST_IDLE: begin
					if (ld_en && !busy_reg && !halt_reg && !start) begin
						case (ld_sel)
							sbx_pkg::SEL_A: a_reg <= ld_data[7:0];
							sbx_pkg::SEL_B: b_reg <= ld_data[7:0];
							sbx_pkg::SEL_C: c_reg <= ld_data[7:0];
							sbx_pkg::SEL_D: d_reg <= ld_data[7:0];
							sbx_pkg::SEL_E: e_reg <= ld_data[7:0];
							sbx_pkg::SEL_H: h_reg <= ld_data[7:0];
							sbx_pkg::SEL_L: l_reg <= ld_data[7:0];
							sbx_pkg::SEL_FLAGS: begin
								s_reg <= ld_data[sbx_pkg::FB_SIGN];
								z_reg <= ld_data[sbx_pkg::FB_ZERO];
								ac_reg <= ld_data[sbx_pkg::FB_HALF];
								p_reg <= ld_data[sbx_pkg::FB_PAR];
								cy_reg <= ld_data[sbx_pkg::FB_CARRY];
							end
							sbx_pkg::SEL_SP: sp_reg <= ld_data;
							sbx_pkg::SEL_PC: pc_reg <= ld_data;
							default: ;
						endcase
					end
					if (accept) begin
						busy_reg <= 1'b1;
						op_reg <= opcode;
						tgt_reg <= next_pc;
						state_reg <= sbx_pkg::ST_DONE;
						if (take_call || is_rst || is_push) begin
							// High byte first, one below the pointer
							mem_addr_reg <= sp_m1;
							// Low byte parked for the second write
							wdata_reg <= is_push ? pair_hi : next_pc[15:8];
							tmp_lo_reg <= is_push ? pair_lo : next_pc[7:0];
							mem_wr_reg <= 1'b1;
							state_reg <= sbx_pkg::ST_PUSH_LO;
							if (take_call)
								tgt_reg <= {imm_hi, imm_lo};
							if (is_rst)
								tgt_reg <= rst_vec;
						end else if (take_ret || is_pop ||
							opcode == sbx_pkg::OP_SWAP_TOP) begin
							mem_addr_reg <= sp_reg;
							mem_rd_reg <= 1'b1;
							state_reg <= sbx_pkg::ST_POP_LO;
						end else if (opcode == sbx_pkg::OP_JMP_PAIR) begin
							tgt_reg <= {h_reg, l_reg};
						end else if (opcode == sbx_pkg::OP_LD_STACK) begin
							sp_reg <= {h_reg, l_reg};
						end else if (opcode == sbx_pkg::OP_IN) begin
							port_reg <= imm_lo;
							io_rd_reg <= 1'b1;
							state_reg <= sbx_pkg::ST_IO_WAIT;
						end else if (opcode == sbx_pkg::OP_OUT) begin
							port_reg <= imm_lo;
							dout_reg <= a_reg;
							oe_reg <= 1'b1;
							io_wr_reg <= 1'b1;
							state_reg <= sbx_pkg::ST_IO_WAIT;
						end else if (is_md) begin
							md_start_reg <= 1'b1;
							state_reg <= sbx_pkg::ST_MULDIV;
						end
					end
				end
				sbx_pkg::ST_PUSH_LO: begin
					mem_addr_reg <= sp_m2;
					wdata_reg <= tmp_lo_reg;
					mem_wr_reg <= 1'b1;
					sp_reg <= sp_m2;
					state_reg <= sbx_pkg::ST_DONE;
				end
				sbx_pkg::ST_POP_LO: begin
					mem_addr_reg <= sp_p1;
					mem_rd_reg <= 1'b1;
					state_reg <= sbx_pkg::ST_POP_HI;
				end
				sbx_pkg::ST_POP_HI: begin
					tmp_lo_reg <= mem_rdata;
					state_reg <= sbx_pkg::ST_POP_END;
				end
				sbx_pkg::ST_POP_END: begin
					state_reg <= sbx_pkg::ST_DONE;
					if (op_swap) begin
						// Write L back first; H follows at sp+1
						mem_addr_reg <= sp_reg;
						wdata_reg <= l_reg;
						mem_wr_reg <= 1'b1;
						tgt_reg <= {mem_rdata, tmp_lo_reg};
						state_reg <= sbx_pkg::ST_SWAP_HI;
					end else if (op_pop) begin
						sp_reg <= sp_p2;
						case (op_reg[5:4])
							2'h0: {b_reg, c_reg} <= {mem_rdata, tmp_lo_reg};
							2'h1: {d_reg, e_reg} <= {mem_rdata, tmp_lo_reg};
							2'h2: {h_reg, l_reg} <= {mem_rdata, tmp_lo_reg};
							default: begin
								a_reg <= mem_rdata;
								s_reg <= tmp_lo_reg[sbx_pkg::FB_SIGN];
								z_reg <= tmp_lo_reg[sbx_pkg::FB_ZERO];
								ac_reg <= tmp_lo_reg[sbx_pkg::FB_HALF];
								p_reg <= tmp_lo_reg[sbx_pkg::FB_PAR];
								cy_reg <= tmp_lo_reg[sbx_pkg::FB_CARRY];
							end
						endcase
					end else begin
						tgt_reg <= {mem_rdata, tmp_lo_reg};
						sp_reg <= sp_p2;
					end
				end
				sbx_pkg::ST_SWAP_HI: begin
					// Pointer itself is left alone
					mem_addr_reg <= sp_p1;
					wdata_reg <= h_reg;
					mem_wr_reg <= 1'b1;
					{h_reg, l_reg} <= tgt_reg;
					tgt_reg <= seq_pc_reg;
					state_reg <= sbx_pkg::ST_DONE;
				end
				sbx_pkg::ST_IO_WAIT: begin
					state_reg <= (op_reg == sbx_pkg::OP_IN) ?
						sbx_pkg::ST_IO_CAP : sbx_pkg::ST_DONE;
				end
				sbx_pkg::ST_IO_CAP: begin
					a_reg <= data_in;
					state_reg <= sbx_pkg::ST_DONE;
				end
				sbx_pkg::ST_MULDIV: begin
					if (md.done) begin
						b_reg <= md.res_hi;
						c_reg <= md.res_lo;
						cy_reg <= md.is_div ? md.res_lo[0] : md.res_hi[7];
						if (md.is_div)
							ac_reg <= 1'b1;
						state_reg <= sbx_pkg::ST_DONE;
					end
				end
				sbx_pkg::ST_DONE: begin
					pc_reg <= tgt_reg;
					done_reg <= 1'b1;
					busy_reg <= 1'b0;
					state_reg <= sbx_pkg::ST_IDLE;
					// Enable is held back one instruction
					if (op_reg == sbx_pkg::OP_IRQ_EN) begin
						ei_pend_reg <= 1'b1;
					end else if (op_reg == sbx_pkg::OP_IRQ_MASK) begin
						inte_reg <= 1'b0;
						ei_pend_reg <= 1'b0;
					end else if (ei_pend_reg) begin
						inte_reg <= 1'b1;
						ei_pend_reg <= 1'b0;
					end
					if (op_reg == sbx_pkg::OP_HALT)
						halt_reg <= 1'b1;
				end
				default: state_reg <= sbx_pkg::ST_IDLE;
			endcase
		end
	end

	// Swap reuses the target register, so keep the sequential address
	always_ff @(posedge clk) begin
		if (rst)
			seq_pc_reg <= sbx_pkg::RST_WORD;
		else if (accept)
			seq_pc_reg <= next_pc;
	end

	// ==========================================================
	// Outputs straight from flops
	assign {mem_addr, mem_wdata, mem_wr, mem_rd} =
		{mem_addr_reg, wdata_reg, mem_wr_reg, mem_rd_reg};
	assign {io_port, io_rd, io_wr, data_out, data_oe} =
		{port_reg, io_rd_reg, io_wr_reg, dout_reg, oe_reg};
	assign {busy, done, halted, irq_enabled} =
		{busy_reg, done_reg, halt_reg, inte_reg};
	assign {acc, reg_b, reg_c, reg_d} = {a_reg, b_reg, c_reg, d_reg};
	assign {reg_e, reg_h, reg_l} = {e_reg, h_reg, l_reg};
	assign {sign_flag, zero_flag, half_carry_flag} = {s_reg, z_reg, ac_reg};
	assign {parity_flag, carry_flag} = {p_reg, cy_reg};
	assign {stack_pointer, program_counter} = {sp_reg, pc_reg};

	// ==========================================================
	// Checks
	sequence two_writes_s;
		mem_wr_reg && mem_addr_reg == $past(sp_reg) - 16'h0001
		##1 mem_wr_reg;
	endsequence
	call_push_a: assert property (@(posedge clk) disable iff (rst)
		accept && take_call |=> two_writes_s ##0 state_reg == sbx_pkg::ST_DONE)
		else $error("call push sequence wrong");
	untaken_a: assert property (@(posedge clk) disable iff (rst)
		accept && is_cret && !cond_ok |=> ##1 pc_reg == $past(next_pc, 2))
		else $error("untaken return did not fall through");
	push_sp_a: assert property (@(posedge clk) disable iff (rst)
		state_reg == sbx_pkg::ST_PUSH_LO |=> sp_reg == $past(sp_reg) - 16'h0002
		&& mem_addr_reg == sp_reg)
		else $error("push pointer step wrong");
	restart_a: assert property (@(posedge clk) disable iff (rst)
		accept && is_rst |=> tgt_reg == {10'h000, $past(opcode[5:3]), 3'b000})
		else $error("restart vector wrong");
	pair_jump_a: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == sbx_pkg::OP_JMP_PAIR |=> ##1
		pc_reg == $past({h_reg, l_reg}, 2))
		else $error("pair jump target wrong");
	stack_load_a: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == sbx_pkg::OP_LD_STACK |=>
		sp_reg == $past({h_reg, l_reg}))
		else $error("stack load wrong");
	out_drive_a: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == sbx_pkg::OP_OUT |=>
		data_oe && io_wr && data_out == $past(a_reg))
		else $error("output not driven");
	ei_delay_a: assert property (@(posedge clk) disable iff (rst)
		state_reg == sbx_pkg::ST_DONE && op_reg == sbx_pkg::OP_IRQ_EN
		&& !inte_reg |=> !inte_reg && ei_pend_reg)
		else $error("enable not delayed");
	di_now_a: assert property (@(posedge clk) disable iff (rst)
		state_reg == sbx_pkg::ST_DONE && op_reg == sbx_pkg::OP_IRQ_MASK
		|=> !inte_reg)
		else $error("mask not immediate");
	halt_hold_a: assert property (@(posedge clk) disable iff (rst)
		halt_reg |=> halt_reg && $stable(a_reg) && $stable(flag_byte)
		&& $stable(sp_reg))
		else $error("halt changed state");
	io_flags_a: assert property (@(posedge clk) disable iff (rst)
		state_reg == sbx_pkg::ST_IO_CAP |=> $stable(flag_byte))
		else $error("input touched flags");
	mul_carry_a: assert property (@(posedge clk) disable iff (rst)
		state_reg == sbx_pkg::ST_MULDIV && md.done && !md.is_div
		|=> cy_reg == b_reg[7])
		else $error("multiply carry wrong");
endmodule : sbx_exec
`default_nettype wire

// ===== bench/sbx_mem_model.sv
// Far-side model: system memory and input ports on the data bus
`timescale 1ns/10ps
`default_nettype none
module sbx_mem_model (
	input wire logic clk,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [7:0] io_port,
	input wire logic io_rd,
	output logic [7:0] mem_rdata,
	output logic [7:0] data_in
);
	logic [7:0] mem [0:65535];
	// ==========================================================
	// Answers
	initial begin
		mem_rdata = 8'h00;
		data_in = 8'h00;
	end
	// Data valid only the cycle after a strobe, inverted otherwise so
	// that a late sample never sees a stale match
	always @(posedge clk) begin
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
		mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
		data_in <= io_rd ? (io_port ^ 8'hc3) : ~data_in;
	end
endmodule : sbx_mem_model
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the stack/branch execution unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start, ld_en, mem_wr, mem_rd, io_rd, io_wr, data_oe, busy, done;
	logic halted, irq_enabled, out_oe, sign_flag, zero_flag;
	logic half_carry_flag, parity_flag, carry_flag;
	logic [3:0] ld_sel;
	logic [7:0] opcode, imm_lo, imm_hi, mem_rdata, mem_wdata, io_port;
	logic [7:0] data_in, data_out, acc, reg_b, reg_c, reg_d, reg_e;
	logic [7:0] reg_h, reg_l, out_port, out_byte;
	logic [15:0] next_pc, ld_data, mem_addr, stack_pointer, program_counter;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	sbx_exec DUT (.clk, .rst, .start, .opcode, .imm_lo, .imm_hi, .next_pc,
		.ld_en, .ld_sel, .ld_data, .mem_rdata, .mem_addr, .mem_wdata,
		.mem_wr, .mem_rd, .io_port, .io_rd, .io_wr, .data_in, .data_out,
		.data_oe, .busy, .done, .halted, .irq_enabled, .acc, .reg_b,
		.reg_c, .reg_d, .reg_e, .reg_h, .reg_l, .sign_flag, .zero_flag,
		.half_carry_flag, .parity_flag, .carry_flag, .stack_pointer,
		.program_counter);
	sbx_mem_model M (.clk, .mem_addr, .mem_wdata, .mem_wr, .mem_rd,
		.io_port, .io_rd, .mem_rdata, .data_in);
	// ==========================================================
	// Clock, hang guard and port-output capture
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish();
		end
		if (io_wr === 1'b1) begin
			out_port <= io_port;
			out_byte <= data_out;
			out_oe <= data_oe;
		end
	end
	// ==========================================================
	// Helpers
	function automatic logic [15:0] flagv();
		return {11'h0, sign_flag, zero_flag, half_carry_flag, parity_flag,
			carry_flag};
	endfunction : flagv
	task automatic chk(input string nm, input logic [15:0] got,
		input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic ld(input logic [3:0] sel, input logic [15:0] d);
		@(posedge clk);
		ld_en <= 1'b1;
		ld_sel <= sel;
		ld_data <= d;
		@(posedge clk);
		ld_en <= 1'b0;
	endtask : ld
	// Start one instruction and wait a bounded time for its done pulse
	task automatic run(input logic [7:0] op, input logic [15:0] npc,
		input logic [15:0] imm);
		int n;
		@(posedge clk);
		start <= 1'b1;
		opcode <= op;
		next_pc <= npc;
		imm_lo <= imm[7:0];
		imm_hi <= imm[15:8];
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 12) begin
			@(negedge clk);
			n++;
		end
		chk("done busy", {14'h0, done, busy}, 16'h0002);
	endtask : run
	// ==========================================================
	// Scenarios
	task automatic t_push_pop();
		ld(sbx_pkg::SEL_SP, 16'h0000);
		ld(sbx_pkg::SEL_B, 16'h0012);
		ld(sbx_pkg::SEL_C, 16'h0034);
		run(8'hc5, 16'h1001, 16'h0000);
		chk("push", {M.mem[16'hffff], M.mem[16'hfffe]}, 16'h1234);
		chk("sp push", stack_pointer, 16'hfffe);
		run(8'hd1, 16'h1002, 16'h0000);
		chk("pop", {reg_d, reg_e}, 16'h1234);
		chk("sp pop", stack_pointer, 16'h0000);
	endtask : t_push_pop
	task automatic t_status();
		ld(sbx_pkg::SEL_A, 16'h00a5);
		ld(sbx_pkg::SEL_FLAGS, 16'h00d5);
		run(8'hf5, 16'h1003, 16'h0000);
		chk("psw", {M.mem[16'hffff], M.mem[16'hfffe]}, 16'ha5d7);
		M.mem[16'hfffe] = 8'h2a;
		M.mem[16'hffff] = 8'h3c;
		run(8'hf1, 16'h1004, 16'h0000);
		chk("pop flags", flagv(), 16'h0000);
		chk("pop acc", 16'(acc), 16'h003c);
		chk("pop sp", stack_pointer, 16'h0000);
	endtask : t_status
	// Every condition code with flags clear, then with flags set
	task automatic t_ccall();
		int f;
		int c;
		logic tk;
		for (f = 0; f < 2; f++) begin
			ld(sbx_pkg::SEL_FLAGS, f ? 16'h00ff : 16'h0000);
			for (c = 0; c < 8; c++) begin
				ld(sbx_pkg::SEL_SP, 16'h0000);
				tk = (c[0] == f[0]);
				run({2'b11, 3'(c), 3'b100}, 16'h0100, 16'h2000 + 16'(c));
				chk("cc pc", program_counter,
					tk ? 16'h2000 + 16'(c) : 16'h0100);
				chk("cc sp", stack_pointer, tk ? 16'hfffe : 16'h0000);
			end
		end
		chk("cc ret", {M.mem[16'hffff], M.mem[16'hfffe]}, 16'h0100);
	endtask : t_ccall
	task automatic t_ret();
		ld(sbx_pkg::SEL_SP, 16'h0000);
		run(8'hcd, 16'h0789, 16'h3456);
		run(8'hc0, 16'h0aaa, 16'h0000);
		chk("rnz pc", program_counter, 16'h0aaa);
		chk("rnz sp", stack_pointer, 16'hfffe);
		run(8'hc8, 16'h0bbb, 16'h0000);
		chk("rz pc", program_counter, 16'h0789);
		chk("rz sp", stack_pointer, 16'h0000);
		// Unconditional return takes the same path
		run(8'hcd, 16'h0456, 16'h3456);
		run(8'hc9, 16'h0ccc, 16'h0000);
		chk("ret pc", program_counter, 16'h0456);
		chk("ret sp", stack_pointer, 16'h0000);
	endtask : t_ret
	task automatic t_restart();
		int n;
		for (n = 0; n < 8; n++) begin
			ld(sbx_pkg::SEL_SP, 16'h0000);
			run({2'b11, 3'(n), 3'b111}, 16'h0bbb, 16'h0000);
			chk("rst pc", program_counter, {10'h0, 3'(n), 3'h0});
			chk("rst sp", stack_pointer, 16'hfffe);
			chk("rst ret", {M.mem[16'hffff], M.mem[16'hfffe]}, 16'h0bbb);
		end
	endtask : t_restart
	task automatic t_swap_jump();
		ld(sbx_pkg::SEL_H, 16'h0077);
		ld(sbx_pkg::SEL_L, 16'h0066);
		ld(sbx_pkg::SEL_SP, 16'hfffe);
		M.mem[16'hfffe] = 8'h11;
		M.mem[16'hffff] = 8'h22;
		run(8'he3, 16'h0c00, 16'h0000);
		chk("swap hl", {reg_h, reg_l}, 16'h2211);
		chk("swap mem", {M.mem[16'hffff], M.mem[16'hfffe]}, 16'h7766);
		chk("swap sp", stack_pointer, 16'hfffe);
		run(8'he9, 16'h0c01, 16'h0000);
		chk("jump pair", program_counter, 16'h2211);
		run(8'hf9, 16'h0c02, 16'h0000);
		chk("load sp", stack_pointer, 16'h2211);
		chk("flags kept", flagv(), 16'h001f);
	endtask : t_swap_jump
	task automatic t_ports();
		ld(sbx_pkg::SEL_A, 16'h00a5);
		run(8'hd3, 16'h0d00, 16'h0042);
		chk("out", {out_port, out_byte}, 16'h42a5);
		chk("out oe", {15'h0, out_oe}, 16'h0001);
		run(8'hdb, 16'h0d02, 16'h003c);
		chk("in", 16'(acc), 16'h00ff);
		chk("io flags", flagv(), 16'h001f);
	endtask : t_ports
	task automatic t_muldiv();
		ld(sbx_pkg::SEL_A, 16'h00ff);
		ld(sbx_pkg::SEL_B, 16'h00ff);
		run(8'hee, 16'h0e00, 16'h0000);
		chk("mul", {reg_b, reg_c}, 16'hfe01);
		chk("mul cy", {15'h0, carry_flag}, 16'h0001);
		ld(sbx_pkg::SEL_A, 16'h0009);
		ld(sbx_pkg::SEL_C, 16'h0064);
		ld(sbx_pkg::SEL_FLAGS, 16'h0000);
		run(8'hfe, 16'h0e01, 16'h0000);
		chk("div", {reg_b, reg_c}, 16'h010b);
		chk("div acc", 16'(acc), 16'h0009);
		chk("div flags", flagv(), 16'h0005);
	endtask : t_muldiv
	// Enable lags one instruction, mask is immediate, halt holds until reset
	task automatic t_control();
		run(8'hfb, 16'h0f01, 16'h0000);
		chk("ei lag", {15'h0, irq_enabled}, 16'h0000);
		run(8'h00, 16'h0f02, 16'h0000);
		chk("ei on", {15'h0, irq_enabled}, 16'h0001);
		chk("idle", {acc, 3'h0, 5'(flagv())}, 16'h0905);
		run(8'hf3, 16'h0f03, 16'h0000);
		chk("di", {15'h0, irq_enabled}, 16'h0000);
		run(8'h76, 16'h0f04, 16'h0000);
		chk("halted", {15'h0, halted}, 16'h0001);
		@(posedge clk);
		start <= 1'b1;
		opcode <= 8'h00;
		next_pc <= 16'h0fff;
		repeat (6) @(posedge clk);
		start <= 1'b0;
		@(negedge clk);
		chk("halt pc", program_counter, 16'h0f04);
		chk("halt regs", {acc, 3'h0, 5'(flagv())}, 16'h0905);
		// Only reset leaves halt; a start right after release is taken
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("reset halt", {15'h0, halted}, 16'h0000);
		run(8'h00, 16'h0123, 16'h0000);
		chk("after reset", program_counter, 16'h0123);
	endtask : t_control
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	// ==========================================================
	// Main sequence
	initial begin
		{start, ld_en, ld_sel, ld_data, opcode, imm_lo, imm_hi} <= '0;
		next_pc <= 16'h0000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_push_pop();
		t_status();
		t_ccall();
		t_ret();
		t_restart();
		t_swap_jump();
		t_ports();
		t_muldiv();
		t_control();
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
